// File: caw_pkg.sv
// Constants shared by the counter array watchdog: addresses, fields, resets.
// Assumes an 8-bit special-function-register bus with 8-bit addresses.
package caw_pkg;
  // ==========================================================================
  // Bus shape
  localparam int SFR_AW = 8;  // Register address width.
  localparam int SFR_DW = 8;  // Register data width.
  // ==========================================================================
  // Register addresses
  localparam logic [7:0] ADDR_CTRL    = 8'hD8;  // array_control_flags.
  localparam logic [7:0] ADDR_MODE    = 8'hD9;  // array_mode_reg.
  localparam logic [7:0] ADDR_CNT_LO  = 8'hF9;  // counter_low_byte.
  localparam logic [7:0] ADDR_CNT_HI  = 8'hFA;  // counter_high_byte.
  localparam logic [7:0] ADDR_OFS     = 8'hCE;  // wdt_offset_byte.
  localparam logic [7:0] ADDR_UPD     = 8'hCF;  // wdt_update_byte.
  localparam logic [7:0] ADDR_UPD_ALT = 8'hEA;  // wdt_update_alias.
  localparam logic [7:0] ADDR_M5MODE  = 8'hDE;  // module5_mode_reg.
  // ==========================================================================
  // Control register fields
  localparam int CTRL_OVF = 7;  // counter_overflow_flag.
  localparam int CTRL_RUN = 6;  // counter_run_bit.
  localparam int CTRL_F5  = 5;  // module5_event_flag.
  // ==========================================================================
  // Mode register fields
  localparam int MODE_IDLE = 7;  // idle_suspend_bit.
  localparam int MODE_WATCHDOG_ENABLE_BIT = 6;  // watchdog_enable_bit.
  localparam int MODE_LOCK = 5;  // watchdog_lock_bit.
  localparam int MODE_TB_H = 3;  // timebase_select high bit.
  localparam int MODE_TB_L = 1;  // timebase_select low bit.
  localparam int MODE_OIE  = 0;  // overflow_irq_enable.
  // ==========================================================================
  // Module mode register fields and forced value
  localparam int M5_ECOM = 6;  // Comparator enable.
  localparam int M5_MAT  = 3;  // Match sets the module flag.
  localparam int M5_IRQ  = 0;  // Module flag interrupt enable.
  localparam logic [7:0] M5_SW_TIMER = 8'h48;  // Software timer mode.
  // ==========================================================================
  // Timebase codes and divisors
  localparam logic [2:0] TB_DIV12 = 3'h0;
  localparam logic [2:0] TB_DIV4  = 3'h1;
  localparam logic [2:0] TB_TMR0  = 3'h2;
  localparam logic [2:0] TB_SYS   = 3'h4;
  localparam logic [3:0] DIV12_LAST = 4'hB;  // Divide by 12, last count.
  localparam logic [3:0] DIV4_LAST  = 4'h3;  // Divide by 4, last count.
  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h40;  // Watchdog enabled at reset.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam int DEF_TIMEOUT_SYSCLK = 3072;  // Reset-default timeout.
endpackage

// File: caw_watchdog.sv
// Counter array watchdog: control/mode registers, 16-bit counter, module 5.
// Assumes a same-clock register bus with one-cycle write and read strobes.
//
// How it works
// - Watchdog comes out of reset enabled.
// - Enabled: module 5 compares limit, holds offset.
// - Enabled watchdog keeps counter running unless idle-suspended in idle.
// - Enabled watchdog ignores counter byte writes.
// - Enabled watchdog freezes timebase and idle bit.
// - Enabled watchdog forces module 5 software timer.
// - Run bit writes cannot stop counter while enabled.
// - Run bit reads zero unless software set.
// - Low overflow at limit match resets system.
// - Update write loads high byte plus offset.
// - Timeout is 256 times offset plus remainder.
// - Writing 1 to module 5 flag resets.
// - Enable or lock bit enables; lock holds.
// - Reset defaults give a 3072 clock timeout.
// - Counter wrap sets overflow flag, software clears.
// - Run bit starts and stops the counter while the watchdog is off.
// - Module flags set by hardware, software clears.
// - Enabled watchdog blocks other mode bits.
// - Idle-suspend bit pauses counter in idle.
// - Timebase select picks divide 12, 4, 1.
`timescale 1ns/1ps
`default_nettype none
module caw_watchdog
  import caw_pkg::*;
(
  input  wire logic                        I_CLK_SYS,
  input  wire logic                        I_RESET_N,
  input  wire logic [caw_pkg::SFR_AW-1:0]  I_SFR_ADDR,
  input  wire logic                        I_SFR_WR,
  input  wire logic [caw_pkg::SFR_DW-1:0]  I_SFR_WDATA,
  input  wire logic                        I_SFR_RD,
  input  wire logic                        I_CPU_IDLE,
  input  wire logic                        I_TIMER0_OVF,
  input  wire logic [4:0]                  I_MODULE_MATCH,
  input  wire logic [4:0]                  I_MODULE_IRQ_EN,
  output logic      [caw_pkg::SFR_DW-1:0]  O_SFR_RDATA,
  output logic                             O_ARRAY_IRQ,
  output logic                             O_WDT_RESET
);
  import caw_pkg::*;

  // ==========================================================================
  // State registers
  logic [7:0]  ctrl_reg,  ctrl_next;   // Overflow flag, run bit, module flags.
  logic [7:0]  mode_reg,  mode_next;   // Mode register as stored.
  logic        lock_reg,  lock_next;   // Lock bit, sticky until reset.
  logic [15:0] cnt_reg,   cnt_next;    // Array counter.
  logic [7:0]  ofs_reg,   ofs_next;    // Module 5 low byte (offset).
  logic [7:0]  lim_reg,   lim_next;    // Module 5 high byte (limit).
  logic [7:0]  m5m_reg,   m5m_next;    // Module 5 mode as software wrote it.
  logic [3:0]  pre_reg,   pre_next;    // Timebase prescaler.
  logic [7:0]  rd_reg,    rd_next;     // Read data holding register.
  logic        rst_reg,   rst_next;    // Watchdog reset pulse.

  // ==========================================================================
  // Derived terms
  logic       wdt_en;     // Watchdog active.
  logic       run;        // Counter allowed to run.
  logic       active;     // Running and not suspended by idle.
  logic       tick;       // One array clock.
  logic [7:0] m5m_eff;    // Module 5 mode as the hardware sees it.
  logic       m5_match;   // Module 5 16-bit compare match.
  logic       fire;       // Watchdog timeout this cycle.
  logic       force_rst;  // Software forced watchdog reset.

  // Address decode shared by the write and read paths.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  // ==========================================================================
  // Timebase and run control
  // Lock enables as well as the enable bit.
  // enable or lock
  assign wdt_en = mode_reg[MODE_WATCHDOG_ENABLE_BIT] | lock_reg;
  // The watchdog overrides the run bit.
  // forced counter run
  assign run    = ctrl_reg[CTRL_RUN] | wdt_en;
  assign active = run & ~(mode_reg[MODE_IDLE] & I_CPU_IDLE);

  // Prescaler tick selection; unlisted sources give no tick here.
  // timebase divide select
  always_comb begin
    pre_next = 4'h0;
    tick     = 1'b0;
    if (active) begin
      case (mode_reg[MODE_TB_H:MODE_TB_L])
        TB_DIV12: begin
          tick     = (pre_reg == DIV12_LAST);
          pre_next = tick ? 4'h0 : pre_reg + 4'h1;
        end
        TB_DIV4: begin
          tick     = (pre_reg >= DIV4_LAST);
          pre_next = tick ? 4'h0 : pre_reg + 4'h1;
        end
        TB_TMR0: tick = I_TIMER0_OVF;
        TB_SYS:  tick = 1'b1;
        default: tick = 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // Module 5 behaviour
  // Watchdog pins module 5 in software timer mode.
  // forced timer mode
  assign m5m_eff  = wdt_en ? M5_SW_TIMER : m5m_reg;
  assign m5_match = tick & m5m_eff[M5_ECOM] & m5m_eff[M5_MAT]
                  & (cnt_reg == {lim_reg, ofs_reg});
  // Timeout fires on the low-byte overflow while the high bytes agree,
  // so the limit counts low-byte overflows after the update.
  // timeout reset
  assign fire      = wdt_en & tick & (cnt_reg[7:0] == BYTE_MAX)
                   & (lim_reg == cnt_reg[15:8]);
  assign force_rst = wdt_en & I_SFR_WR & hit(I_SFR_ADDR, ADDR_CTRL)
                   & I_SFR_WDATA[CTRL_F5];

  // ==========================================================================
  // Register next-state logic
  always_comb begin
    ctrl_next = ctrl_reg;
    mode_next = mode_reg;
    lock_next = lock_reg;
    cnt_next  = tick ? cnt_reg + 16'h0001 : cnt_reg;
    ofs_next  = ofs_reg;
    lim_next  = lim_reg;
    m5m_next  = m5m_reg;
    rd_next   = rd_reg;
    // A single-cycle pulse is enough for the reset controller.
    // reset pulse
    rst_next  = fire | force_rst;
    if (I_SFR_WR) begin
      // Software writes flags; hardware sets below take precedence.
      if (hit(I_SFR_ADDR, ADDR_CTRL)) begin
        ctrl_next = I_SFR_WDATA;
      end
      if (hit(I_SFR_ADDR, ADDR_MODE)) begin
        // Enabled watchdog only lets the enable and lock bits change.
        // A lock keeps the fields frozen after the enable bit is cleared.
        // frozen timebase and idle
        if (wdt_en) begin
          mode_next[MODE_WATCHDOG_ENABLE_BIT] = I_SFR_WDATA[MODE_WATCHDOG_ENABLE_BIT];
        end else begin
          mode_next = I_SFR_WDATA;
          mode_next[4] = 1'b0;
        end
        mode_next[MODE_LOCK] = 1'b0;
        lock_next = lock_reg | I_SFR_WDATA[MODE_LOCK];
      end
      if (!wdt_en && hit(I_SFR_ADDR, ADDR_CNT_LO)) begin
        cnt_next[7:0] = I_SFR_WDATA;
      end
      if (!wdt_en && hit(I_SFR_ADDR, ADDR_CNT_HI)) begin
        cnt_next[15:8] = I_SFR_WDATA;
      end
      if (hit(I_SFR_ADDR, ADDR_OFS)) begin
        ofs_next = I_SFR_WDATA;
        m5m_next[M5_ECOM] = wdt_en ? m5m_reg[M5_ECOM] : 1'b0;
      end
      if (hit(I_SFR_ADDR, ADDR_UPD) || hit(I_SFR_ADDR, ADDR_UPD_ALT)) begin
        // With the watchdog enabled, either update address reloads the limit from the running count.
        // update reload
        if (wdt_en) begin
          lim_next = cnt_reg[15:8] + ofs_reg;
        end else if (hit(I_SFR_ADDR, ADDR_UPD)) begin
          lim_next = I_SFR_WDATA;
          m5m_next[M5_ECOM] = 1'b1;
        end
      end
      if (!wdt_en && hit(I_SFR_ADDR, ADDR_M5MODE)) begin
        m5m_next = I_SFR_WDATA;
      end
    end
    // Hardware event flags win over a same-cycle software clear.
    // overflow flag
    if (tick && cnt_reg == CNT_MAX) begin
      ctrl_next[CTRL_OVF] = 1'b1;
    end
    for (int i = 0; i < 5; i++) begin
      if (I_MODULE_MATCH[i]) begin
        ctrl_next[i] = 1'b1;
      end
    end
    if (m5_match) begin
      ctrl_next[CTRL_F5] = 1'b1;
    end
    // Registered read data; unmapped addresses read zero.
    if (I_SFR_RD) begin
      rd_next = 8'h00;
      if (hit(I_SFR_ADDR, ADDR_CTRL))    rd_next = ctrl_reg;
      if (hit(I_SFR_ADDR, ADDR_MODE))    rd_next = mode_reg | {2'b00, lock_reg, 5'h00};
      if (hit(I_SFR_ADDR, ADDR_CNT_LO))  rd_next = cnt_reg[7:0];
      if (hit(I_SFR_ADDR, ADDR_CNT_HI))  rd_next = cnt_reg[15:8];
      if (hit(I_SFR_ADDR, ADDR_OFS))     rd_next = ofs_reg;
      if (hit(I_SFR_ADDR, ADDR_UPD))     rd_next = lim_reg;
      if (hit(I_SFR_ADDR, ADDR_M5MODE))  rd_next = m5m_eff;
    end
  end

  // Registers only; reset values give the default watchdog timeout.
  // enabled at reset
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ctrl_reg <= RST_CTRL;
      mode_reg <= RST_MODE;
      lock_reg <= 1'b0;
      cnt_reg  <= 16'h0000;
      ofs_reg  <= RST_BYTE;
      lim_reg  <= RST_BYTE;
      m5m_reg  <= RST_BYTE;
      pre_reg  <= 4'h0;
      rd_reg   <= RST_BYTE;
      rst_reg  <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      mode_reg <= mode_next;
      lock_reg <= lock_next;
      cnt_reg  <= cnt_next;
      ofs_reg  <= ofs_next;
      lim_reg  <= lim_next;
      m5m_reg  <= m5m_next;
      pre_reg  <= pre_next;
      rd_reg   <= rd_next;
      rst_reg  <= rst_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign O_SFR_RDATA = rd_reg;
  assign O_WDT_RESET = rst_reg;
  // Overflow and module flags request the shared array interrupt.
  assign O_ARRAY_IRQ = (ctrl_reg[CTRL_OVF] & mode_reg[MODE_OIE])
                     | (|(ctrl_reg[4:0] & I_MODULE_IRQ_EN))
                     | (ctrl_reg[CTRL_F5] & m5m_eff[M5_IRQ]);

  // ==========================================================================
  // Assertions
  logic wr_ctrl, wr_mode, wr_cnt, wr_upd;
  assign wr_ctrl = I_SFR_WR & hit(I_SFR_ADDR, ADDR_CTRL);
  assign wr_mode = I_SFR_WR & hit(I_SFR_ADDR, ADDR_MODE);
  assign wr_cnt  = I_SFR_WR & (hit(I_SFR_ADDR, ADDR_CNT_LO) | hit(I_SFR_ADDR, ADDR_CNT_HI));
  assign wr_upd  = I_SFR_WR & hit(I_SFR_ADDR, ADDR_UPD);

  sequence timeout_cond;
    wdt_en && tick && cnt_reg[7:0] == BYTE_MAX && lim_reg == cnt_reg[15:8];
  endsequence

  sequence update_write;
    wdt_en && wr_upd;
  endsequence

  reset_enabled_a: assert property (@(posedge I_CLK_SYS)
    $rose(I_RESET_N) |-> wdt_en) else $error("Watchdog not enabled after reset.");
  counter_forced_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    wdt_en && tick && !wr_cnt |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("Counter did not advance under watchdog.");
  cnt_write_block_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    wdt_en && wr_cnt && !tick |=> $stable(cnt_reg)) else $error("Counter write accepted.");
  mode_frozen_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    wdt_en && wr_mode |=> $stable(mode_reg[MODE_IDLE])
      && $stable(mode_reg[MODE_TB_H:MODE_TB_L])) else $error("Mode bits changed.");
  timer_forced_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    wdt_en |-> m5m_eff == M5_SW_TIMER) else $error("Module 5 not in timer mode.");
  run_readback_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    wdt_en && !ctrl_reg[CTRL_RUN] && I_SFR_RD && hit(I_SFR_ADDR, ADDR_CTRL)
    |=> !O_SFR_RDATA[CTRL_RUN]) else $error("Run bit read as one.");
  timeout_fire_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    timeout_cond |=> O_WDT_RESET) else $error("Timeout reset missing.");
  // A second cycle high is legal only when a fresh cause stood in the first.
  reset_pulse_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    O_WDT_RESET |=> !O_WDT_RESET
      || $past(wdt_en && ((tick && cnt_reg[7:0] == BYTE_MAX && lim_reg == cnt_reg[15:8])
      || (wr_ctrl && I_SFR_WDATA[CTRL_F5])))) else $error("Reset pulse too long.");
  update_load_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    update_write |=> lim_reg == $past(cnt_reg[15:8]) + $past(ofs_reg))
    else $error("Update did not reload limit.");
  force_reset_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    wdt_en && wr_ctrl && I_SFR_WDATA[CTRL_F5] |=> O_WDT_RESET)
    else $error("Forced reset missing.");
  lock_hold_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    lock_reg |=> wdt_en && lock_reg) else $error("Locked watchdog disabled.");
  overflow_set_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    tick && cnt_reg == CNT_MAX |=> ctrl_reg[CTRL_OVF]) else $error("Overflow flag not set.");
endmodule
`default_nettype wire

// File: caw_cpu_model.sv
// CPU-side model: issues strobed register writes and reads.
// Assumes the same clock as the watchdog and a one-cycle read latency.
`timescale 1ns/1ps
`default_nettype none
module caw_cpu_model
  import caw_pkg::*;
(
  input  wire logic                        i_clk,
  input  wire logic [caw_pkg::SFR_DW-1:0]  i_rdata,
  output logic      [caw_pkg::SFR_AW-1:0]  o_addr,
  output logic                             o_wr,
  output logic      [caw_pkg::SFR_DW-1:0]  o_wdata,
  output logic                             o_rd
);
  int unsigned idle_cycles = 0;  // Extra idle cycles before an access.
  initial begin
    o_addr  = '0;
    o_wr    = 1'b0;
    o_wdata = '0;
    o_rd    = 1'b0;
  end
  // ==========================================================================
  // Accesses
  // Released lines show the inverse value, so stale data never matches.
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    repeat (idle_cycles) @(posedge i_clk);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask
  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    repeat (idle_cycles) @(posedge i_clk);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

// File: tb_counter_array_watchdog.sv
// Self-checking bench for the counter array watchdog.
// Assumes caw_pkg, caw_watchdog and caw_cpu_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb_counter_array_watchdog;
  import caw_pkg::*;
  typedef struct packed { logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp; } caw_row_t;
  logic       clk = 1'b0;          // System clock.
  logic       rst_n = 1'b0;        // Active-low reset.
  logic [7:0] addr, wdata, rdata;  // Register bus.
  logic       wr, rd, wdt_rst, irq;
  logic       idle = 1'b0;         // CPU idle level.
  logic [4:0] match = '0;          // Module match pulses.
  logic [4:0] match_en = 5'h01;    // Module interrupt enables.
  logic [7:0] d;                   // Read-back value.
  int         num_errors = 0;
  int         cmp_count = 0;
  int         cyc, n;
  // Rows: address, written value, expected read-back with the watchdog off.
  caw_row_t rows [0:6] = '{'{ADDR_MODE, 8'h9F, 8'h8F}, '{ADDR_MODE, 8'h00, 8'h00},
    '{ADDR_OFS, 8'h12, 8'h12}, '{ADDR_CNT_LO, 8'h34, 8'h34}, '{ADDR_CNT_HI, 8'hAB, 8'hAB},
    '{ADDR_CTRL, 8'h00, 8'h00}, '{8'h00, 8'h5A, 8'h00}};
  initial begin
    forever #4 clk = ~clk;
  end
  // Cycles since the last reset release, used to time the watchdog.
  always @(posedge clk) begin
    cyc <= rst_n ? cyc + 1 : 0;
  end
  caw_cpu_model cpu_u (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
    .o_wdata(wdata), .o_rd(rd));
  caw_watchdog dut_u (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_SFR_ADDR(addr), .I_SFR_WR(wr),
    .I_SFR_WDATA(wdata), .I_SFR_RD(rd), .I_CPU_IDLE(idle), .I_TIMER0_OVF(1'b0),
    .I_MODULE_MATCH(match), .I_MODULE_IRQ_EN(match_en), .O_SFR_RDATA(rdata),
    .O_ARRAY_IRQ(irq), .O_WDT_RESET(wdt_rst));
  // ==========================================================================
  // Closing and helpers
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Waits for the reset pulse, counting cycles; gives up after a bound.
  task automatic wait_pulse(output int c);
    c = 0;
    while (wdt_rst !== 1'b1 && c < 5000) begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask
  // Counter low-byte advance across exactly 48 clocks: the two read strobes
  // are taken 48 edges apart, so every timebase gives a whole number of ticks.
  // Needs the CPU model's idle_cycles at zero.
  task automatic count_rate(output logic [7:0] delta);
    logic [7:0] a, b;
    cpu_u.sfr_read(ADDR_CNT_LO, a);
    repeat (46) @(posedge clk);
    cpu_u.sfr_read(ADDR_CNT_LO, b);
    delta = b - a;
  endtask
  // The run needs about 5300 clocks; this bound leaves a wide margin.
  initial begin
    #(20000 * 8);
    num_errors++;
    report_and_stop();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    cpu_u.sfr_read(ADDR_MODE, d);
    `CHK(d, 8'h40)
    cpu_u.sfr_read(ADDR_CTRL, d);
    `CHK(d, 8'h00)
    wait_pulse(n);
    `CHK((cyc >= 3070 && cyc <= 3075), 1'b1)
    @(posedge clk);
    #1;
    `CHK(wdt_rst, 1'b0)
    $display("test reset defaults done");
    cpu_u.sfr_write(ADDR_MODE, 8'hCE);
    cpu_u.sfr_read(ADDR_MODE, d);
    `CHK(d, 8'h40)
    cpu_u.sfr_write(ADDR_CNT_HI, 8'h80);
    cpu_u.sfr_read(ADDR_CNT_HI, d);
    `CHK((d !== 8'h80), 1'b1)
    $display("test frozen fields done");
    // disable first, then a slow CPU walks the table
    cpu_u.sfr_write(ADDR_MODE, 8'h00);
    cpu_u.idle_cycles = 3;
    foreach (rows[i]) begin
      cpu_u.sfr_write(rows[i].addr, rows[i].wdata);
      cpu_u.sfr_read(rows[i].addr, d);
      `CHK(d, rows[i].exp)
    end
    cpu_u.idle_cycles = 0;
    $display("test register table done");
    // wrap sets the overflow flag on the undivided clock
    cpu_u.sfr_write(ADDR_CNT_LO, 8'hF0);
    cpu_u.sfr_write(ADDR_CNT_HI, 8'hFF);
    cpu_u.sfr_write(ADDR_MODE, 8'h09);
    cpu_u.sfr_write(ADDR_CTRL, 8'h40);
    count_rate(d);
    `CHK(d, 8'h30)
    cpu_u.sfr_read(ADDR_CTRL, d);
    `CHK(d, 8'hC0)
    `CHK(irq, 1'b1)
    @(posedge clk);
    match <= 5'h01;
    @(posedge clk);
    match <= 5'h00;
    cpu_u.sfr_read(ADDR_CTRL, d);
    `CHK(d, 8'hC1)
    cpu_u.sfr_write(ADDR_CTRL, 8'h00);
    count_rate(d);
    `CHK(d, 8'h00)
    `CHK(irq, 1'b0)
    $display("test flags done");
    cpu_u.sfr_write(ADDR_MODE, 8'h82);
    cpu_u.sfr_write(ADDR_CTRL, 8'h40);
    count_rate(d);
    `CHK(d, 8'h0C)
    idle <= 1'b1;
    count_rate(d);
    `CHK(d, 8'h00)
    idle <= 1'b0;
    cpu_u.sfr_write(ADDR_CTRL, 8'h00);
    $display("test timebase done");
    // configure: timebase, offset, enable, then update
    cpu_u.sfr_write(ADDR_CNT_LO, 8'h00);
    cpu_u.sfr_write(ADDR_CNT_HI, 8'h00);
    cpu_u.sfr_write(ADDR_MODE, 8'h08);
    cpu_u.sfr_write(ADDR_OFS, 8'h02);
    cpu_u.sfr_write(ADDR_MODE, 8'h48);
    cpu_u.sfr_write(ADDR_UPD, 8'h77);
    wait_pulse(n);
    `CHK((n >= 760 && n <= 772), 1'b1)
    // service inside the window, through the alias
    cpu_u.sfr_write(ADDR_UPD, 8'h00);
    repeat (500) @(posedge clk);
    cpu_u.sfr_write(ADDR_UPD_ALT, 8'hFF);
    wait_pulse(n);
    `CHK((n >= 516 && n <= 524), 1'b1)
    $display("test update timeout done");
    // lock keeps the watchdog on and the fields frozen
    cpu_u.sfr_write(ADDR_MODE, 8'h00);
    cpu_u.sfr_write(ADDR_MODE, 8'h20);
    cpu_u.sfr_write(ADDR_MODE, 8'h08);
    cpu_u.sfr_read(ADDR_MODE, d);
    `CHK(d, 8'h20)
    cpu_u.sfr_read(ADDR_CTRL, d);
    `CHK(d[6], 1'b0)
    count_rate(d);
    `CHK(d, 8'h04)
    // forced reset, pulse seen right after the write edge
    cpu_u.sfr_write(ADDR_CTRL, 8'h20);
    #1;
    `CHK(wdt_rst, 1'b1)
    // Second reset clears the lock.
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    cpu_u.sfr_read(ADDR_MODE, d);
    `CHK(d, 8'h40)
    $display("test lock done");
    report_and_stop();
  end
endmodule
`default_nettype wire
